/* common/gpmx_pkg.sv */
package gpmx_pkg;

  localparam int unsigned GPMX_PINS = 6;

  // Pin positions
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_SSN = 2;
  localparam int unsigned PIN_TXD = 3;
  localparam int unsigned PIN_RXD = 4;
  localparam int unsigned PIN_SCK = 5;

  // Strap codes on pins one and zero
  localparam logic [1:0] STRAP_DEBUG = 2'h1;
  localparam logic [1:0] STRAP_PROG = 2'h2;

  // Reset values of the configuration
  localparam logic [5:0] RST_DATA = 6'h00;
  localparam logic [5:0] RST_DIR = 6'h00;
  localparam logic [5:0] RST_PULL = 6'h00;
  localparam logic [5:0] RST_WAKE = 6'h00;

  // Cycles after reset release before the strap is caught
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [1:0] {
    GPMX_NORMAL,
    GPMX_DEBUG,
    GPMX_PROG
  } gpmx_mode_e;

  typedef struct packed {
    logic [5:0] data;
    logic [5:0] dir;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
    logic [5:0] wake_en;
    logic [5:0] wake_pol;
  } gpmx_cfg_s;

  typedef struct packed {
    logic i2c_scl_oe;
    logic i2c_scl_out;
    logic i2c_sda_oe;
    logic i2c_sda_out;
    logic uart_en;
    logic uart_mode0;
    logic uart_txd;
    logic uart_rclk;
    logic spi_en;
    logic spi_master;
    logic spi_dma;
    logic spi_ssn_out;
    logic spi_mosi_out;
    logic spi_miso_out;
    logic spi_sclk_out;
    logic pwm_en;
    logic pwm_channel_zero;
    logic pwm_channel_one;
    logic test_en;
    logic test0;
    logic test1;
    logic rf_data;
  } gpmx_alt_s;

  typedef struct packed {
    logic [5:0] drive;
    logic [5:0] value;
  } gpmx_pad_s;

endpackage

/* logic/gpmx_sync.sv */
`timescale 1ns/10ps
module gpmx_sync
  import gpmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [GPMX_PINS-1:0] async_in,
  output logic [GPMX_PINS-1:0] sync_out
);

  logic [GPMX_PINS-1:0] meta_q;
  logic [GPMX_PINS-1:0] meta_d;
  logic [GPMX_PINS-1:0] sync_q;
  logic [GPMX_PINS-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

/* logic/gpmx_port.sv */
`timescale 1ns/10ps
// Operation
// RL1: Six port pins, read and driven by software through plain ports.
// RL2: Power-on strap on pins one and zero: 01 debug, 10 programming.
// RL3: Any pin may wake from power-down or resume from idle.
// RL4: I2C enabled puts clock on pin zero, data on pin one.
// RL5: Outside party or internal pull-up supplies I2C weak high.
// RL6: UART enabled drives transmit on pin three, receives on pin four.
// RL7: UART mode 0 drives receive clock out on pin four.
// RL8: SPI maps select, MOSI, MISO, clock to pins two to five.
// RL9: Select is input normally, output as DMA master.
// RL10: Timer PWM channel zero on pin two, channel one on four.
// RL11: RF data enable sends encoder stream on pin two.
// RL12: Pin five can supply the external system clock.
// RL13: Each pin has software-selectable pull-up and pull-down.
// RL14: Configuration held through power-down and thermal shutdown.
// RL15: Unclaimed pins are plain GPIO by direction and data register.
module gpmx_port
  import gpmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire gpmx_cfg_s cfg_in,
  input wire logic cfg_we,
  input wire logic i2c_pin_enable,
  input wire logic rf_data_pin_enable,
  input wire logic ext_clk_sel,
  input wire gpmx_alt_s alt,
  input wire logic [GPMX_PINS-1:0] pad_in,
  output logic [GPMX_PINS-1:0] pad_out,
  output logic [GPMX_PINS-1:0] pad_oe_n,
  output logic [GPMX_PINS-1:0] pad_pull_up,
  output logic [GPMX_PINS-1:0] pad_pull_down,
  output logic [GPMX_PINS-1:0] port_read,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic uart_rxd_in,
  output logic spi_ssn_in,
  output logic spi_mosi_in,
  output logic spi_miso_in,
  output logic spi_sclk_in,
  output logic external_system_clock_in,
  output logic wake_event,
  output gpmx_mode_e boot_mode,
  output logic boot_mode_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [GPMX_PINS-1:0] pin_s;

  gpmx_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pad_in),
    .sync_out(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  gpmx_cfg_s cfg_q;
  gpmx_cfg_s cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    // RL14 held across low power
    // RL1 software port access
    if (cfg_we) begin
      cfg_d = cfg_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.data <= RST_DATA;
      cfg_q.dir <= RST_DIR;
      cfg_q.pull_up <= RST_PULL;
      cfg_q.pull_down <= RST_PULL;
      cfg_q.wake_en <= RST_WAKE;
      cfg_q.wake_pol <= RST_WAKE;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot strap capture

  logic [1:0] settle_q;
  logic [1:0] settle_d;
  gpmx_mode_e mode_q;
  gpmx_mode_e mode_d;
  logic mode_valid_q;
  logic mode_valid_d;

  function automatic gpmx_mode_e strap_decode(input logic [1:0] code);
    if (code == STRAP_DEBUG) begin
      strap_decode = GPMX_DEBUG;
    end else if (code == STRAP_PROG) begin
      strap_decode = GPMX_PROG;
    end else begin
      strap_decode = GPMX_NORMAL;
    end
  endfunction

  always_comb begin
    settle_d = settle_q;
    mode_d = mode_q;
    mode_valid_d = mode_valid_q;
    // RL2 strap sampled once
    if (!mode_valid_q) begin
      if (settle_q == STRAP_SETTLE) begin
        mode_d = strap_decode({pin_s[PIN_SDA], pin_s[PIN_SCL]});
        mode_valid_d = 1'b1;
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 2'h0;
      mode_q <= GPMX_NORMAL;
      mode_valid_q <= 1'b0;
    end else begin
      settle_q <= settle_d;
      mode_q <= mode_d;
      mode_valid_q <= mode_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output multiplexer

  logic [GPMX_PINS-1:0] out_d;
  logic [GPMX_PINS-1:0] drv_d;
  logic [GPMX_PINS-1:0] out_q;
  logic [GPMX_PINS-1:0] oe_n_q;
  logic ssn_drive;

  always_comb begin
    // RL15 default GPIO behaviour
    out_d = cfg_q.data;
    drv_d = cfg_q.dir;
    // RL9 select direction
    ssn_drive = alt.spi_master && alt.spi_dma;

    // RL4 I2C pin zero and one
    if (i2c_pin_enable) begin
      out_d[PIN_SCL] = alt.i2c_scl_out;
      drv_d[PIN_SCL] = alt.i2c_scl_oe;
      out_d[PIN_SDA] = alt.i2c_sda_out;
      drv_d[PIN_SDA] = alt.i2c_sda_oe;
    end

    // RL10 PWM channel zero
    if (alt.pwm_en) begin
      out_d[PIN_SSN] = alt.pwm_channel_zero;
      drv_d[PIN_SSN] = 1'b1;
    end
    // RL11 RF stream out
    if (rf_data_pin_enable) begin
      out_d[PIN_SSN] = alt.rf_data;
      drv_d[PIN_SSN] = 1'b1;
    end

    // Test outputs on pins three and four
    if (alt.test_en) begin
      out_d[PIN_TXD] = alt.test0;
      drv_d[PIN_TXD] = 1'b1;
      out_d[PIN_RXD] = alt.test1;
      drv_d[PIN_RXD] = 1'b1;
    end

    // RL10 PWM channel one
    if (alt.pwm_en) begin
      out_d[PIN_RXD] = alt.pwm_channel_one;
      drv_d[PIN_RXD] = 1'b1;
    end

    // RL6 UART transmit pin
    if (alt.uart_en) begin
      out_d[PIN_TXD] = alt.uart_txd;
      drv_d[PIN_TXD] = 1'b1;
      // RL7 mode 0 clock out
      out_d[PIN_RXD] = alt.uart_mode0 ? alt.uart_rclk : 1'b0;
      drv_d[PIN_RXD] = alt.uart_mode0;
    end

    // RL8 SPI pin map
    if (alt.spi_en) begin
      out_d[PIN_SSN] = alt.spi_ssn_out;
      drv_d[PIN_SSN] = ssn_drive;
      out_d[PIN_TXD] = alt.spi_mosi_out;
      drv_d[PIN_TXD] = alt.spi_master;
      out_d[PIN_RXD] = alt.spi_miso_out;
      drv_d[PIN_RXD] = !alt.spi_master;
      out_d[PIN_SCK] = alt.spi_sclk_out;
      drv_d[PIN_SCK] = alt.spi_master;
    end

    // RL12 clock input pin
    if (ext_clk_sel) begin
      out_d[PIN_SCK] = 1'b0;
      drv_d[PIN_SCK] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= '0;
      oe_n_q <= '1;
    end else begin
      out_q <= out_d;
      oe_n_q <= ~drv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull resistors and input routing

  logic [GPMX_PINS-1:0] pu_d;
  logic [GPMX_PINS-1:0] pu_q;
  logic [GPMX_PINS-1:0] pd_q;
  logic [GPMX_PINS-1:0] read_q;
  logic [7:0] route_q;
  logic [7:0] route_d;

  always_comb begin
    // RL13 software pulls
    pu_d = cfg_q.pull_up;
    // RL5 pull-up kept under software
    route_d[0] = pin_s[PIN_SCL];
    route_d[1] = pin_s[PIN_SDA];
    route_d[2] = pin_s[PIN_RXD];
    route_d[3] = pin_s[PIN_SSN];
    route_d[4] = pin_s[PIN_TXD];
    route_d[5] = pin_s[PIN_RXD];
    route_d[6] = pin_s[PIN_SCK];
    route_d[7] = pin_s[PIN_SCK];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pu_q <= RST_PULL;
      pd_q <= RST_PULL;
      read_q <= '0;
      route_q <= 8'h00;
    end else begin
      pu_q <= pu_d;
      pd_q <= cfg_q.pull_down;
      read_q <= pin_s;
      route_q <= route_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake detection

  logic [GPMX_PINS-1:0] prev_q;
  logic [GPMX_PINS-1:0] hit;
  logic wake_q;
  logic wake_d;

  generate
    for (genvar i = 0; i < GPMX_PINS; i++) begin : g_wake
      // RL3 per-pin wake edge
      assign hit[i] = cfg_q.wake_en[i] &&
                      (pin_s[i] != prev_q[i]) &&
                      (pin_s[i] == cfg_q.wake_pol[i]);
    end
  endgenerate

  always_comb begin
    wake_d = |hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
      wake_q <= 1'b0;
    end else begin
      prev_q <= pin_s;
      wake_q <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output assignments

  assign pad_out = out_q;
  assign pad_oe_n = oe_n_q;
  assign pad_pull_up = pu_q;
  assign pad_pull_down = pd_q;
  assign port_read = read_q;
  assign i2c_scl_in = route_q[0];
  assign i2c_sda_in = route_q[1];
  assign uart_rxd_in = route_q[2];
  assign spi_ssn_in = route_q[3];
  assign spi_mosi_in = route_q[4];
  assign spi_miso_in = route_q[5];
  assign spi_sclk_in = route_q[6];
  assign external_system_clock_in = route_q[7];
  assign wake_event = wake_q;
  assign boot_mode = mode_q;
  assign boot_mode_valid = mode_valid_q;

endmodule

/* verification/gpmx_props.sv */
`timescale 1ns/10ps
module gpmx_props
  import gpmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire gpmx_cfg_s cfg_in,
  input wire logic cfg_we,
  input wire logic i2c_pin_enable,
  input wire logic rf_data_pin_enable,
  input wire logic ext_clk_sel,
  input wire gpmx_alt_s alt,
  input wire logic [GPMX_PINS-1:0] pad_in,
  input wire logic [GPMX_PINS-1:0] pad_out,
  input wire logic [GPMX_PINS-1:0] pad_oe_n,
  input wire logic [GPMX_PINS-1:0] pad_pull_up,
  input wire logic [GPMX_PINS-1:0] port_read,
  input wire gpmx_mode_e boot_mode,
  input wire logic boot_mode_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_i2c_clk_pin: assert property (i2c_pin_enable |=> pad_out[0] == $past(alt.i2c_scl_out))
    else $error("i2c clock pin wrong");
  a_uart_tx_pin: assert property (alt.uart_en && !alt.spi_en |=>
    !pad_oe_n[3] && pad_out[3] == $past(alt.uart_txd))
    else $error("uart transmit pin wrong");
  a_uart_rclk_out: assert property (alt.uart_en && alt.uart_mode0 && !alt.spi_en |=>
    !pad_oe_n[4] && pad_out[4] == $past(alt.uart_rclk))
    else $error("uart receive clock pin wrong");
  a_ssn_dir_pin: assert property (alt.spi_en |=>
    pad_oe_n[2] != $past(alt.spi_master && alt.spi_dma))
    else $error("select direction wrong");
  a_rf_data_pin: assert property (rf_data_pin_enable && !alt.spi_en |=>
    pad_out[2] == $past(alt.rf_data))
    else $error("rf data pin wrong");
  a_pwm_zero_pin: assert property (alt.pwm_en && !alt.spi_en && !rf_data_pin_enable |=>
    pad_out[2] == $past(alt.pwm_channel_zero))
    else $error("pwm pin wrong");
  a_pin_read_path: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
    port_read == $past(pad_in, 3))
    else $error("pin read wrong");
  a_pull_cfg_out: assert property (cfg_we |=> ##1 pad_pull_up == $past(cfg_in.pull_up, 2))
    else $error("pull up wrong");
  a_strap_mode: assert property ($rose(boot_mode_valid) |-> boot_mode ==
    (port_read[1:0] == STRAP_DEBUG ? GPMX_DEBUG :
    port_read[1:0] == STRAP_PROG ? GPMX_PROG : GPMX_NORMAL))
    else $error("boot mode wrong");
  a_ext_clk_pin: assert property (ext_clk_sel |=> pad_oe_n[5])
    else $error("clock input pin driven");

  c_i2c: cover property (i2c_pin_enable && alt.i2c_scl_out);
  c_dbg: cover property ($rose(boot_mode_valid) && boot_mode == GPMX_DEBUG);
  c_dma: cover property (alt.spi_en && alt.spi_master && alt.spi_dma);
endmodule

bind gpmx_port gpmx_props u_props (.clk, .rst, .cfg_in, .cfg_we, .i2c_pin_enable,
  .rf_data_pin_enable, .ext_clk_sel, .alt, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up,
  .port_read,
  .boot_mode, .boot_mode_valid);

/* verification/gpmx_board.sv */
`timescale 1ns/10ps
module gpmx_board
  import gpmx_pkg::*;
(
  input wire logic clk,
  input wire logic [GPMX_PINS-1:0] pad_out,
  input wire logic [GPMX_PINS-1:0] pad_oe_n,
  input wire logic [GPMX_PINS-1:0] pad_pull_up,
  input wire logic [GPMX_PINS-1:0] pad_pull_down,
  input wire logic [GPMX_PINS-1:0] ext_en,
  input wire logic [GPMX_PINS-1:0] ext_val,
  output logic [GPMX_PINS-1:0] pad_in
);
  logic [GPMX_PINS-1:0] float_q = 6'h15;
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < GPMX_PINS; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_q[i];
    end
  end
endmodule

/* verification/test_gpmx_port.sv */
`timescale 1ns/10ps
module test_gpmx_port
  import gpmx_pkg::*;
;
  logic clk, rst, cfg_we, i2c_pin_enable, rf_data_pin_enable, ext_clk_sel, wake_event;
  logic i2c_scl_in, i2c_sda_in, uart_rxd_in, spi_ssn_in, spi_mosi_in, spi_miso_in;
  logic spi_sclk_in, external_system_clock_in, boot_mode_valid;
  logic [5:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, port_read, ext_en;
  logic [5:0] ext_val, w;
  logic [11:0] m;
  logic [31:0] seed = 32'h00011F49;
  logic [31:0] r;
  gpmx_cfg_s cfg_in;
  gpmx_alt_s alt;
  gpmx_mode_e boot_mode;
  int errors = 0;
  int num_checks = 0;

  gpmx_port dut (.clk, .rst, .cfg_in, .cfg_we, .i2c_pin_enable, .rf_data_pin_enable,
    .ext_clk_sel, .alt, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down,
    .port_read, .i2c_scl_in, .i2c_sda_in, .uart_rxd_in, .spi_ssn_in, .spi_mosi_in,
    .spi_miso_in, .spi_sclk_in, .external_system_clock_in, .wake_event, .boot_mode,
    .boot_mode_valid);
  gpmx_board u_board (.clk, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .ext_en,
    .ext_val, .pad_in);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [5:0] mode_of(logic [1:0] s);
    return s == STRAP_DEBUG ? {4'h0, GPMX_DEBUG} : s == STRAP_PROG ? {4'h0, GPMX_PROG} :
      {4'h0, GPMX_NORMAL};
  endfunction

  function automatic logic [11:0] mux_exp(gpmx_alt_s a, logic i2c, logic rf, logic xclk);
    logic [5:0] o;
    logic [5:0] d;
    // GPIO data and direction zero here
    o = 6'h00;
    d = 6'h00;
    if (i2c) begin
      o[1:0] = {a.i2c_sda_out, a.i2c_scl_out};
      d[1:0] = {a.i2c_sda_oe, a.i2c_scl_oe};
    end
    if (a.spi_en) begin
      {o[2], d[2]} = {a.spi_ssn_out, a.spi_master & a.spi_dma};
    end else if (rf) begin
      {o[2], d[2]} = {a.rf_data, 1'b1};
    end else if (a.pwm_en) begin
      {o[2], d[2]} = {a.pwm_channel_zero, 1'b1};
    end
    if (a.spi_en) begin
      {o[3], d[3]} = {a.spi_mosi_out, a.spi_master};
    end else if (a.uart_en) begin
      {o[3], d[3]} = {a.uart_txd, 1'b1};
    end else if (a.test_en) begin
      {o[3], d[3]} = {a.test0, 1'b1};
    end
    if (a.spi_en) begin
      {o[4], d[4]} = {a.spi_miso_out, ~a.spi_master};
    end else if (a.uart_en) begin
      {o[4], d[4]} = {a.uart_mode0 & a.uart_rclk, a.uart_mode0};
    end else if (a.pwm_en) begin
      {o[4], d[4]} = {a.pwm_channel_one, 1'b1};
    end else if (a.test_en) begin
      {o[4], d[4]} = {a.test1, 1'b1};
    end
    if (xclk) begin
      {o[5], d[5]} = 2'h0;
    end else if (a.spi_en) begin
      {o[5], d[5]} = {a.spi_sclk_out, a.spi_master};
    end
    return {~d, o};
  endfunction

  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_cfg(input gpmx_cfg_s c);
    @(posedge clk);
    cfg_in <= c;
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    {rst, cfg_we, i2c_pin_enable, rf_data_pin_enable, ext_clk_sel} = 5'h10;
    cfg_in = '0;
    alt = '0;
    ext_en = 6'h3F;
    ext_val = 6'h00;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      ext_val <= 6'(c);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (STRAP_SETTLE) @(posedge clk);
      #1;
      chk("mode_valid_early", 6'h00, {5'h00, boot_mode_valid});
      @(posedge clk);
      #1;
      chk("boot_mode_valid", 6'h01, {5'h00, boot_mode_valid});
      chk("boot_mode", mode_of(2'(c)), {4'h0, boot_mode});
      repeat (3) @(posedge clk);
    end
    $display("test strap done");
    for (int n = 0; n < 8; n++) begin
      wr_cfg(36'({rnd(), rnd()}));
      chk("pad_oe_n", ~cfg_in.dir, pad_oe_n);
      chk("pad_out", cfg_in.data & cfg_in.dir, pad_out & cfg_in.dir);
      chk("pad_pull_up", cfg_in.pull_up, pad_pull_up);
      chk("pad_pull_down", cfg_in.pull_down, pad_pull_down);
    end
    repeat (10) @(posedge clk);
    chk("pull_kept", cfg_in.pull_up, pad_pull_up);
    $display("test config done");
    wr_cfg('0);
    ext_clk_sel <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      ext_val <= 6'(rnd());
      repeat (3) @(posedge clk);
      #1;
      chk("port_read", ext_val, port_read);
      chk("route_in", ext_val, {external_system_clock_in, uart_rxd_in, spi_mosi_in,
        spi_ssn_in, i2c_sda_in, i2c_scl_in});
      chk("route_spi", {4'h0, ext_val[5:4]}, {4'h0, spi_sclk_in, spi_miso_in});
    end
    $display("test read done");
    ext_val <= 6'h00;
    wr_cfg({24'h0, 12'hFFF});
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      ext_val <= e == 0 ? 6'h08 : 6'h00;
      w = 6'h00;
      repeat (8) begin
        @(posedge clk);
        #1;
        w = w + 6'(wake_event);
      end
      chk("wake_count", e == 0 ? 6'h01 : 6'h00, w);
    end
    $display("test wake done");
    repeat (60) begin
      @(posedge clk);
      r = rnd();
      alt <= r[21:0];
      {ext_clk_sel, rf_data_pin_enable, i2c_pin_enable} <= r[24:22];
      ext_en <= r[30:25];
      ext_val <= 6'(rnd());
      @(posedge clk);
      #1;
      m = mux_exp(alt, i2c_pin_enable, rf_data_pin_enable, ext_clk_sel);
      chk("mux_pad_out", m[5:0], pad_out);
      chk("mux_pad_oe_n", m[11:6], pad_oe_n);
    end
    $display("test mux done");
    final_report();
  end
endmodule
